// [logic/dcmc_ctrl.sv]
// mode, stop / power-down and phase-alignment control of the clock generator
`timescale 1ns/100ps
`include "dcmc_params.svh"

// Overview of operation
// - detector steers aligner to zero error
// - rising edges only
// - multiplier rate is reference times A/B
// - ratio pins select A and B
// - stop high: complementary aligner outputs
// - stop low: drivers high impedance
// - mode pins: normal, bypass, test
// - code 01x: outputs high impedance
// - power-off: source off, outputs undriven
// - power-off dominates, then stop
// - power-up follows pins
// - transition glitches allowed
// - ratio change down or running
// - standard channel rates supported
// - outputs off soon after stop
// - phase settles in 20 output cycles
// - ratio resettles within 1 ms
// - power-up settles within 3 ms
module dcmc_ctrl #(
	parameter int POWERUP_CYC = `DCMC_TPOWERUP_MS * `DCMC_CLK_KHZ, // 3 ms
	parameter int MULT_CYC    = `DCMC_TMULT_MS * `DCMC_CLK_KHZ     // 1 ms
) (
	input  wire logic        clk,                 // clock
	input  wire logic        rst,                 // reset
	input  wire logic        powerOffN,           // power-down pin
	input  wire logic        stopN,               // stop pin
	input  wire logic        modeSel0,            // mode pin
	input  wire logic        modeSel1,            // mode pin
	input  wire logic        modeSel2,            // mode pin
	input  wire logic        ratioSel0,           // ratio pin
	input  wire logic        ratioSel1,           // ratio pin
	input  wire logic        ratioSel2,           // ratio pin
	input  wire logic        refClock,            // reference
	input  wire logic        dividedCtrlClock,    // detector input
	input  wire logic        dividedChannelClock, // detector input
	output logic             clkTrue,             // true data
	output logic             clkTrueOe,           // true enable
	output logic             clkComp,             // comp data
	output logic             clkCompOe,           // comp enable
	output logic             sourceOn,            // source on
	input  wire logic [31:0] s_axi_awaddr,        // aw addr
	input  wire logic        s_axi_awvalid,       // aw valid
	output logic             s_axi_awready,       // aw ready
	input  wire logic [31:0] s_axi_wdata,         // w data
	input  wire logic [3:0]  s_axi_wstrb,         // w strobes
	input  wire logic        s_axi_wvalid,        // w valid
	output logic             s_axi_wready,        // w ready
	output logic [1:0]       s_axi_bresp,         // b resp
	output logic             s_axi_bvalid,        // b valid
	input  wire logic        s_axi_bready,        // b ready
	input  wire logic [31:0] s_axi_araddr,        // ar addr
	input  wire logic        s_axi_arvalid,       // ar valid
	output logic             s_axi_arready,       // ar ready
	output logic [31:0]      s_axi_rdata,         // r data
	output logic [1:0]       s_axi_rresp,         // r resp
	output logic             s_axi_rvalid,        // r valid
	input  wire logic        s_axi_rready         // r ready
);
	localparam logic [16:0] PowerupCnt = 17'(POWERUP_CYC);
	localparam logic [16:0] MultCnt    = 17'(MULT_CYC);

	dcmc_pkg::dcmc_ctrl_t q;
	dcmc_pkg::dcmc_ctrl_t next_q;
	dcmc_pkg::dcmc_pins_t rawPins;
	dcmc_pkg::dcmc_pins_t pins;
	dcmc_pkg::dcmc_pwr_t  decoded;
	logic                 ratioValid;
	logic                 mulClock;
	logic                 ctrlRise;
	logic                 chanRise;
	logic                 modeValid;
	logic                 outRise;
	logic                 source;
	logic                 driveOn;
	logic                 awTake;
	logic                 wTake;
	logic                 arTake;
	logic [1:0]           arIdx;
	logic                 arOk;
	logic [31:0]          statusWord;

	// ----------------------------------------------------------------
	// pin synchronisers and multiplier
	// ----------------------------------------------------------------
	assign rawPins = {powerOffN, stopN, modeSel0, modeSel1, modeSel2, ratioSel0, ratioSel1,
		ratioSel2, refClock, dividedCtrlClock, dividedChannelClock};

	dcmc_sync u_sync (
		.clk     (clk),
		.rst     (rst),
		.pinsIn  (rawPins),
		.pinsOut (pins)
	);

	// source off in power-down
	dcmc_nco u_nco (
		.clk      (clk),
		.rst      (rst),
		.enable   (q.pwr != dcmc_pkg::PWR_DOWN),
		.ratioSel (q.ratio),
		.valid    (ratioValid),
		.mulClock (mulClock)
	);

	// ----------------------------------------------------------------
	// bus handshakes: one write and one read in flight
	// ----------------------------------------------------------------
	assign s_axi_awready = !q.awHave && !q.bValid;
	assign s_axi_wready  = !q.wHave && !q.bValid;
	assign s_axi_arready = !q.rValid;
	assign awTake = s_axi_awvalid && s_axi_awready;
	assign wTake  = s_axi_wvalid && s_axi_wready;
	assign arTake = s_axi_arvalid && s_axi_arready;
	assign arIdx  = s_axi_araddr[3:2];
	assign arOk   = (s_axi_araddr <= 32'(`DCMC_ADDR_PHASE)) && (s_axi_araddr[1:0] == 2'b00);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	always_comb begin
		if (!pins.powerOffN) begin
			decoded = dcmc_pkg::PWR_DOWN;
		end else if (!pins.stopN) begin
			decoded = dcmc_pkg::CLK_STOP;
		end else begin
			decoded = dcmc_pkg::RUN;
		end
	end

	always_comb begin
		// vendor and reserved codes: undriven
		case (q.mode)
			`DCMC_MODE_NORMAL: modeValid = ratioValid;
			`DCMC_MODE_BYPASS: modeValid = ratioValid;
			`DCMC_MODE_TEST:   modeValid = 1'b1;
			default:           modeValid = 1'b0;
		endcase
	end

	always_comb begin
		case (q.mode)
			`DCMC_MODE_BYPASS: source = mulClock;
			`DCMC_MODE_TEST:   source = pins.refClock;
			default:           source = q.hist[q.tap];
		endcase
	end

	// a pending settle may not start the drivers, even through a stop release
	assign driveOn = (q.pwr == dcmc_pkg::RUN) && modeValid
		&& ((q.mode & `DCMC_OETEST_MASK) != `DCMC_OETEST_CODE)
		&& !(q.settleCnt != 17'h00000 && !q.out.enable);

	assign ctrlRise = pins.ctrlClock && !q.prevCtrl;
	assign chanRise = pins.chanClock && !q.prevChan;
	assign outRise  = q.out.clock && !q.prevOut;

	assign statusWord = 32'({q.stopCnt == 5'h00, q.settleCnt == 17'h00000, ratioValid,
		modeValid, q.ratio, q.mode, q.pwr});

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;

		// no fixed state; glitches tolerated
		next_q.pwr = decoded;

		// mode latched in power-down
		if (q.pwr == dcmc_pkg::PWR_DOWN) begin
			next_q.mode = pins.modeSel;
		end

		// settle timers
		if (q.settleCnt != 17'h00000) begin
			next_q.settleCnt = q.settleCnt - 17'h00001;
		end
		if (decoded == dcmc_pkg::PWR_DOWN) begin
			next_q.settleCnt = 17'h00000;
		end else if (q.pwr == dcmc_pkg::PWR_DOWN) begin
			next_q.settleCnt = PowerupCnt;
		end
		if (pins.ratioSel != q.ratio) begin
			next_q.ratio = pins.ratioSel;
			if (q.pwr == dcmc_pkg::RUN && decoded == dcmc_pkg::RUN) begin
				next_q.settleCnt = MultCnt;
			end
		end

		// stop resettle counts output rises
		if (q.pwr == dcmc_pkg::CLK_STOP && decoded == dcmc_pkg::RUN) begin
			next_q.stopCnt = `DCMC_STOP_SETTLE;
		end else if (decoded != dcmc_pkg::RUN) begin
			next_q.stopCnt = 5'h00;
		end else if (outRise && q.stopCnt != 5'h00) begin
			next_q.stopCnt = q.stopCnt - 5'h01;
		end

		// aligner delay line and rising-edge phase detector
		next_q.hist = {q.hist[14:0], mulClock};
		next_q.prevCtrl = pins.ctrlClock;
		next_q.prevChan = pins.chanClock;
		if (!q.loopEn || q.mode != `DCMC_MODE_NORMAL || q.pwr == dcmc_pkg::PWR_DOWN) begin
			next_q.ctrlSeen = 1'b0;
			next_q.chanSeen = 1'b0;
		end else if (ctrlRise && chanRise) begin
			next_q.ctrlSeen = 1'b0;
			next_q.chanSeen = 1'b0;
		end else if (ctrlRise) begin
			if (q.chanSeen) begin
				// channel edge came first: delay the output more
				next_q.chanSeen = 1'b0;
				if (q.tap != 4'hF) begin
					next_q.tap = q.tap + 4'h1;
				end
			end else begin
				next_q.ctrlSeen = 1'b1;
			end
		end else if (chanRise) begin
			if (q.ctrlSeen) begin
				// channel edge came late: pull the output earlier
				next_q.ctrlSeen = 1'b0;
				if (q.tap != 4'h0) begin
					next_q.tap = q.tap - 4'h1;
				end
			end else begin
				next_q.chanSeen = 1'b1;
			end
		end

		// data low while undriven
		next_q.prevOut = q.out.clock;
		next_q.out.enable = driveOn;
		next_q.out.clock = driveOn & source;
		next_q.out.clockN = driveOn & ~source;

		// write channel
		if (awTake) begin
			next_q.awHave = 1'b1;
			next_q.awIdx = s_axi_awaddr[3:2];
			next_q.awOk = (s_axi_awaddr <= 32'(`DCMC_ADDR_PHASE))
				&& (s_axi_awaddr[1:0] == 2'b00);
		end
		if (wTake) begin
			next_q.wHave = 1'b1;
			next_q.wBit = s_axi_wdata[0];
			next_q.wStrb0 = s_axi_wstrb[0];
		end
		if (q.awHave && q.wHave) begin
			next_q.awHave = 1'b0;
			next_q.wHave = 1'b0;
			next_q.bValid = 1'b1;
			next_q.bResp = q.awOk ? `DCMC_RESP_OKAY : `DCMC_RESP_SLVERR;
			if (q.awOk && q.wStrb0 && {q.awIdx, 2'b00} == `DCMC_ADDR_CTRL) begin
				next_q.loopEn = q.wBit;
			end
		end
		if (q.bValid && s_axi_bready) begin
			next_q.bValid = 1'b0;
		end

		// status and phase read-only
		if (arTake) begin
			next_q.rValid = 1'b1;
			next_q.rResp = arOk ? `DCMC_RESP_OKAY : `DCMC_RESP_SLVERR;
			next_q.rData = 32'h00000000;
			if (arOk) begin
				case ({arIdx, 2'b00})
					`DCMC_ADDR_CTRL:   next_q.rData = 32'({q.loopEn});
					`DCMC_ADDR_STATUS: next_q.rData = statusWord;
					`DCMC_ADDR_PHASE:  next_q.rData = 32'({q.tap});
					default:           next_q.rData = 32'h00000000;
				endcase
			end
		end else if (q.rValid && s_axi_rready) begin
			next_q.rValid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.pwr <= dcmc_pkg::PWR_DOWN;
			q.tap <= `DCMC_TAP_RESET;
			q.loopEn <= `DCMC_CTRL_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign clkTrue      = q.out.clock;
	assign clkComp      = q.out.clockN;
	assign clkTrueOe    = q.out.enable;
	assign clkCompOe    = q.out.enable;
	assign sourceOn     = (q.pwr != dcmc_pkg::PWR_DOWN);
	assign s_axi_bvalid = q.bValid;
	assign s_axi_bresp  = q.bResp;
	assign s_axi_rvalid = q.rValid;
	assign s_axi_rdata  = q.rData;
	assign s_axi_rresp  = q.rResp;
endmodule // dcmc_ctrl

// [logic/dcmc_params.svh]
// named constants for the differential clock mode control block
`ifndef DCMC_PARAMS_SVH
`define DCMC_PARAMS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define DCMC_ADDR_CTRL      4'h0
`define DCMC_ADDR_STATUS    4'h4
`define DCMC_ADDR_PHASE     4'h8
`define DCMC_CTRL_RESET     1'b1
`define DCMC_RESP_OKAY      2'b00
`define DCMC_RESP_SLVERR    2'b10

// ----------------------------------------------------------------
// mode select codes, written {modeSel0, modeSel1, modeSel2}
// ----------------------------------------------------------------
`define DCMC_MODE_NORMAL    3'b000
`define DCMC_MODE_BYPASS    3'b100
`define DCMC_MODE_TEST      3'b110
`define DCMC_OETEST_MASK    3'b110
`define DCMC_OETEST_CODE    3'b010

// ----------------------------------------------------------------
// multiply select codes, written {ratioSel0, ratioSel1, ratioSel2}
// ----------------------------------------------------------------
`define DCMC_RATIO_4_1      3'b000
`define DCMC_RATIO_9_2      3'b001
`define DCMC_RATIO_6_1      3'b010
`define DCMC_RATIO_8_3      3'b100
`define DCMC_RATIO_16_3     3'b101
`define DCMC_RATIO_8_1      3'b110

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCMC_CLK_KHZ        40000
`define DCMC_TPOWERUP_MS    3
`define DCMC_TMULT_MS       1
`define DCMC_STOP_SETTLE    5'd20
`define DCMC_NCO_WRAP       9'h040
`define DCMC_TAP_RESET      4'h8

`endif

// [logic/dcmc_pkg.sv]
// types shared by the differential clock mode control block
package dcmc_pkg;

	// ----------------------------------------------------------------
	// power / stop state, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PWR_DOWN = 3'b001,
		CLK_STOP = 3'b010,
		RUN      = 3'b100
	} dcmc_pwr_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       powerOffN;
		logic       stopN;
		logic [2:0] modeSel;
		logic [2:0] ratioSel;
		logic       refClock;
		logic       ctrlClock;
		logic       chanClock;
	} dcmc_pins_t;

	typedef struct packed {
		logic clock;
		logic clockN;
		logic enable;
	} dcmc_clkout_t;

	// ----------------------------------------------------------------
	// module state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [10:0] s1;
		logic [10:0] s2;
		logic [10:0] s3;
		logic [10:0] val;
	} dcmc_sync_t;

	typedef struct packed {
		logic [8:0] acc;
		logic       clk;
	} dcmc_nco_t;

	typedef struct packed {
		dcmc_pwr_t    pwr;
		logic [2:0]   mode;
		logic [2:0]   ratio;
		logic [16:0]  settleCnt;
		logic [4:0]   stopCnt;
		logic [15:0]  hist;
		logic [3:0]   tap;
		logic         ctrlSeen;
		logic         chanSeen;
		logic         prevCtrl;
		logic         prevChan;
		logic         prevOut;
		dcmc_clkout_t out;
		logic         loopEn;
		logic         awHave;
		logic [1:0]   awIdx;
		logic         awOk;
		logic         wHave;
		logic         wBit;
		logic         wStrb0;
		logic         bValid;
		logic [1:0]   bResp;
		logic         rValid;
		logic [31:0]  rData;
		logic [1:0]   rResp;
	} dcmc_ctrl_t;

endpackage

// [logic/dcmc_sync.sv]
// three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/100ps
`include "dcmc_params.svh"
module dcmc_sync (
	input  wire logic              clk,     // system clock
	input  wire logic              rst,     // synchronous reset
	input  wire dcmc_pkg::dcmc_pins_t pinsIn,  // raw pin levels
	output dcmc_pkg::dcmc_pins_t   pinsOut  // filtered levels
);
	dcmc_pkg::dcmc_sync_t q;
	dcmc_pkg::dcmc_sync_t next_q;
	logic [10:0]          agree;

	always_comb begin
		next_q = q;
		agree = ~(q.s2 ^ q.s3);
		next_q.s1 = pinsIn;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		next_q.val = (agree & q.s3) | (~agree & q.val);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign pinsOut = q.val;
endmodule // dcmc_sync

// [logic/dcmc_nco.sv]
// multiply-ratio decode and digital model of the multiplier clock
`timescale 1ns/100ps
`include "dcmc_params.svh"
module dcmc_nco (
	input  wire logic       clk,      // system clock
	input  wire logic       rst,      // synchronous reset
	input  wire logic       enable,   // clock source powered
	input  wire logic [2:0] ratioSel, // {ratioSel0, ratioSel1, ratioSel2}
	output logic            valid,    // code is a defined ratio
	output logic            mulClock  // multiplier_out_clock model
);
	dcmc_pkg::dcmc_nco_t q;
	dcmc_pkg::dcmc_nco_t next_q;
	logic [4:0]          divA;
	logic [1:0]          divB;
	logic [8:0]          wrapAt;
	logic [8:0]          sum;

	// feedback divider A and prescaler B
	always_comb begin
		valid = 1'b1;
		case (ratioSel)
			`DCMC_RATIO_4_1:  begin divA = 5'h04; divB = 2'h1; end
			`DCMC_RATIO_9_2:  begin divA = 5'h09; divB = 2'h2; end
			`DCMC_RATIO_6_1:  begin divA = 5'h06; divB = 2'h1; end
			`DCMC_RATIO_8_3:  begin divA = 5'h08; divB = 2'h3; end
			`DCMC_RATIO_16_3: begin divA = 5'h10; divB = 2'h3; end
			`DCMC_RATIO_8_1:  begin divA = 5'h08; divB = 2'h1; end
			default: begin
				divA = 5'h00;
				divB = 2'h1;
				valid = 1'b0;
			end
		endcase
	end

	// rate is clk * A / (2 * B * wrap); the reference is clk / (2 * wrap)
	always_comb begin
		next_q = q;
		wrapAt = 9'(divB * `DCMC_NCO_WRAP);
		sum = q.acc + 9'(divA);
		if (!enable || !valid) begin
			next_q = '0;
		end else if (sum >= wrapAt) begin
			next_q.acc = sum - wrapAt;
			next_q.clk = ~q.clk;
		end else begin
			next_q.acc = sum;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign mulClock = q.clk;
endmodule // dcmc_nco

// [verif/dcmc_ctrl_assertions.sv]
// port checks for the clock mode control block
`timescale 1ns/100ps
`include "dcmc_params.svh"
module dcmc_ctrl_assertions #(
	parameter int POWERUP_CYC = 120000 // output hold after power-up
) (
	input wire logic        clk,           // system clock
	input wire logic        rst,           // synchronous reset
	input wire logic        powerOffN,     // power-down pin
	input wire logic        stopN,         // stop pin
	input wire logic        modeSel0,      // mode pin 0
	input wire logic        modeSel1,      // mode pin 1
	input wire logic        clkTrue,       // true data
	input wire logic        clkTrueOe,     // true enable
	input wire logic        clkComp,       // complement data
	input wire logic        clkCompOe,     // complement enable
	input wire logic        sourceOn,      // source powered
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic        s_axi_wvalid,  // w valid
	input wire logic        s_axi_wready,  // w ready
	input wire logic [1:0]  s_axi_bresp,   // b resp
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_bready,  // b ready
	input wire logic [31:0] s_axi_araddr,  // ar addr
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [1:0]  s_axi_rresp,   // r resp
	input wire logic        s_axi_rvalid   // r valid
);
	// ------
	// helper
	// ------
	logic [17:0] upCnt; // cycles since source on
	always_ff @(posedge clk) begin
		if (rst || !sourceOn)
			upCnt <= 18'h00000;
		else if (upCnt != 18'h3FFFF)
			upCnt <= upCnt + 18'h00001;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_comp_pair: assert property (clkTrueOe |-> clkCompOe && clkComp == !clkTrue)
		else $error("complement output not paired");
	a_undriven_low: assert property (!clkTrueOe |-> !clkTrue && !clkComp)
		else $error("undriven output carries data");
	a_stop_off: assert property (!stopN [*8] |-> !clkTrueOe)
		else $error("drivers on while stopped");
	a_power_off: assert property (!powerOffN [*8] |-> !sourceOn && !clkTrueOe)
		else $error("source on in power-down");
	a_source_up: assert property (powerOffN [*8] |-> sourceOn)
		else $error("source off while powered");
	a_oe_test: assert property ((!modeSel0 && modeSel1) [*8] |-> !clkTrueOe)
		else $error("drivers on in output test");
	a_powerup_hold: assert property (clkTrueOe |-> upCnt >= POWERUP_CYC - 2)
		else $error("drivers on before power-up hold");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
			&& s_axi_wready |-> ##[1:4] s_axi_bvalid)
		else $error("write response missing");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
			&& $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
			&& s_axi_araddr == 32'h0000000C |-> ##[1:2] s_axi_rvalid
			&& s_axi_rresp == `DCMC_RESP_SLVERR)
		else $error("unmapped read not refused");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
endmodule // dcmc_ctrl_assertions

bind dcmc_ctrl dcmc_ctrl_assertions #(.POWERUP_CYC(POWERUP_CYC)) u_chk (.*);

// [verif/dcmc_far_end.sv]
// controller core model feeding the two divided phase detector clocks
`timescale 1ns/100ps
module dcmc_far_end (
	input  wire logic       clk,      // bench clock
	input  wire logic       active,   // detector inputs in use
	input  wire logic [4:0] ctrlLag,  // controller rise offset
	input  wire logic [4:0] chanLag,  // channel rise offset
	input  wire logic [4:0] chanHigh, // channel high time
	output logic            ctrlClk,  // divided controller clock
	output logic            chanClk   // divided channel clock
);
	// one shared count keeps both rates equal
	logic [4:0] cnt = 5'h00;
	logic       on  = 1'b0;
	// gate at a period boundary: no half pair
	always @(posedge clk) begin
		cnt <= cnt + 5'h01;
		if (cnt == 5'h1F)
			on <= active;
	end
	assign ctrlClk = on && (cnt - ctrlLag) < 5'h10;
	assign chanClk = on && (cnt - chanLag) < chanHigh;
endmodule // dcmc_far_end

// [verif/differential_clock_mode_control_test.sv]
// self-checking bench for the clock mode control block
`timescale 1ns/100ps
`include "dcmc_params.svh"
module differential_clock_mode_control_test;
	localparam int PU  = 50;   // shortened power-up hold
	localparam int MU  = 20;   // shortened ratio settle
	localparam int WIN = 1536; // count window, whole reference periods
	logic        clk = 1'b0, rst = 1'b1, pwrN = 1'b0, stopN = 1'b1, fActive = 1'b0;
	logic [2:0]  mode = 3'h0, ratio = 3'h0;
	logic [6:0]  refCnt = 7'h00;
	logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic [3:0]  awAddr = 4'h0, arAddr = 4'h0;
	logic [31:0] wData = 32'h00000000, rData;
	logic        awReady, wReady, bValid, arReady, rValid, ctrlClk, chanClk;
	logic        clkTrue, trueOe, clkComp, compOe, srcOn;
	logic [1:0]  bResp, rResp, lastResp;
	logic [4:0]  cLag = 5'h00, nLag = 5'h00, nHigh = 5'h10;
	int          n_fail = 0, checks = 0;

	always #12.5 clk = ~clk;
	always @(posedge clk) refCnt <= refCnt + 7'h01;

	dcmc_ctrl #(.POWERUP_CYC(PU), .MULT_CYC(MU)) u_dut (.clk(clk), .rst(rst), .powerOffN(pwrN),
		.stopN(stopN), .modeSel0(mode[2]), .modeSel1(mode[1]), .modeSel2(mode[0]),
		.ratioSel0(ratio[2]), .ratioSel1(ratio[1]), .ratioSel2(ratio[0]), .refClock(refCnt[6]),
		.dividedCtrlClock(ctrlClk), .dividedChannelClock(chanClk), .clkTrue(clkTrue),
		.clkTrueOe(trueOe), .clkComp(clkComp), .clkCompOe(compOe), .sourceOn(srcOn),
		.s_axi_awaddr({28'h0000000, awAddr}), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr({28'h0000000, arAddr}), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
	dcmc_far_end u_far (.clk(clk), .active(fActive), .ctrlLag(cLag), .chanLag(nLag),
		.chanHigh(nHigh), .ctrlClk(ctrlClk), .chanClk(chanClk));

	// ------
	// helpers
	// ------
	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] want, input logic [31:0] got);
		checks++;
		if (got !== want) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, want, got);
		end
	endtask
	task automatic hang(input string what);
		n_fail++;
		$display("[FAIL] %s expected answer seen timeout", what);
		results;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
		int i;
		logic done;
		done = 1'b0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (i = 0; i < 40 && !done; i++) begin
			@(posedge clk);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
			if (bValid) begin
				done = 1'b1;
				lastResp = bResp;
				bReady <= 1'b0;
			end
		end
		if (!done) hang("write");
		@(posedge clk);
	endtask
	task automatic axiRd(input logic [3:0] a, output logic [31:0] d);
		int i;
		logic done;
		done = 1'b0;
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (i = 0; i < 40 && !done; i++) begin
			@(posedge clk);
			if (arReady) arValid <= 1'b0;
			if (rValid) begin
				done = 1'b1;
				d = rData;
				lastResp = rResp;
				rReady <= 1'b0;
			end
		end
		if (!done) hang("read");
		@(posedge clk);
	endtask
	task automatic waitOe(input int lim);
		for (int i = 0; i < lim && trueOe !== 1'b1; i++)
			@(posedge clk);
		if (trueOe !== 1'b1) hang("output enable");
	endtask
	task automatic powerCycle(input logic [2:0] m);
		pwrN <= 1'b0;
		tick(8);
		mode <= m;
		tick(8);
		pwrN <= 1'b1;
		tick(PU + 40);
	endtask
	// one edge slack for a cut period
	task automatic countEdges(input int want, input string what);
		int n;
		logic prev;
		n = 0;
		prev = clkTrue;
		repeat (WIN) begin
			@(posedge clk);
			if (trueOe === 1'b1 && clkTrue === 1'b1 && prev === 1'b0) n++;
			prev = clkTrue;
		end
		checks++;
		if (n < want - 1 || n > want + 1) begin
			n_fail++;
			$display("[FAIL] %s expected %0d seen %0d", what, want, n);
		end
	endtask

	// ------
	// scenarios
	// ------
	task automatic testRegs;
		logic [31:0] d;
		axiRd(`DCMC_ADDR_CTRL, d);
		check("loop enable reset", 32'h1, 32'(d[0]));
		axiRd(`DCMC_ADDR_PHASE, d);
		check("tap reset", 32'(`DCMC_TAP_RESET), 32'(d[3:0]));
		axiRd(4'hC, d);
		check("unmapped read resp", 32'(`DCMC_RESP_SLVERR), 32'(lastResp));
		check("unmapped read data", 32'h0, d);
		axiWr(4'hC, 32'h0);
		check("unmapped write resp", 32'(`DCMC_RESP_SLVERR), 32'(lastResp));
		axiWr(`DCMC_ADDR_CTRL, 32'h0);
		axiRd(`DCMC_ADDR_CTRL, d);
		check("loop enable cleared", 32'h0, 32'(d[0]));
		axiWr(`DCMC_ADDR_CTRL, 32'h1);
		axiRd(`DCMC_ADDR_STATUS, d);
		check("state power-down", 32'(dcmc_pkg::PWR_DOWN), 32'(d[2:0]));
		$display("test registers done");
	endtask
	task automatic testStates;
		logic [31:0] d;
		pwrN <= 1'b1;
		stopN <= 1'b0;
		tick(10);
		check("source on in stop", 32'h1, 32'(srcOn));
		axiRd(`DCMC_ADDR_STATUS, d);
		check("state stop", 32'(dcmc_pkg::CLK_STOP), 32'(d[2:0]));
		stopN <= 1'b1;
		waitOe(PU + 40);
		axiRd(`DCMC_ADDR_STATUS, d);
		check("state run", 32'(dcmc_pkg::RUN), 32'(d[2:0]));
		stopN <= 1'b0;
		tick(8);
		check("stopped enable", 32'h0, 32'(trueOe));
		stopN <= 1'b1;
		waitOe(40);
		axiRd(`DCMC_ADDR_STATUS, d);
		check("settle pending", 32'h0, 32'(d[12]));
		tick(800);
		axiRd(`DCMC_ADDR_STATUS, d);
		check("phase settled", 32'h1, 32'(d[12]));
		pwrN <= 1'b0;
		tick(8);
		check("source off", 32'h0, 32'(srcOn));
		$display("test states done");
	endtask
	task automatic testModes;
		logic [2:0] codes [8];
		int         want [8];
		codes = '{3'b000, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001, 3'b101, 3'b111};
		want = '{WIN * 4 / 128, WIN * 4 / 128, WIN / 128, 0, 0, 0, 0, 0};
		foreach (codes[k]) begin
			powerCycle(codes[k]);
			countEdges(want[k], "mode output edges");
		end
		$display("test modes done");
	endtask
	task automatic testRatios;
		logic [2:0]  codes [8];
		int          a [8];
		int          b [8];
		logic [31:0] d;
		codes = '{3'b001, 3'b010, 3'b100, 3'b101, 3'b110, 3'b000, 3'b011, 3'b111};
		a = '{9, 6, 8, 16, 8, 4, 0, 0};
		b = '{2, 1, 3, 3, 1, 1, 1, 1};
		powerCycle(3'b100);
		foreach (codes[k]) begin
			ratio <= codes[k];
			tick(6);
			if (a[k] != 0) begin
				axiRd(`DCMC_ADDR_STATUS, d);
				check("ratio settle pending", 32'h0, 32'(d[11]));
			end
			tick(MU + 10);
			if (a[k] != 0) begin
				axiRd(`DCMC_ADDR_STATUS, d);
				check("ratio settled", 32'h1, 32'(d[11]));
			end
			countEdges(WIN * a[k] / (128 * b[k]), "bypass output edges");
		end
		$display("test ratios done");
	endtask
	task automatic phaseStep(input logic [4:0] cl, input logic [4:0] nl, input logic [4:0] nh,
			input int dir);
		logic [31:0] t0, t1;
		logic        ok;
		axiRd(`DCMC_ADDR_PHASE, t0);
		cLag <= cl;
		nLag <= nl;
		nHigh <= nh;
		fActive <= 1'b1;
		tick(100);
		fActive <= 1'b0;
		tick(40);
		axiRd(`DCMC_ADDR_PHASE, t1);
		ok = dir < 0 ? t1[3:0] < t0[3:0] : dir > 0 ? t1[3:0] > t0[3:0] : t1[3:0] == t0[3:0];
		check("tap direction", 32'h1, 32'(ok));
	endtask
	task automatic testPhase;
		ratio <= 3'b000;
		powerCycle(3'b000);
		phaseStep(5'h00, 5'h04, 5'h10, -1);
		phaseStep(5'h04, 5'h00, 5'h10, 1);
		phaseStep(5'h00, 5'h00, 5'h08, 0);
		axiWr(`DCMC_ADDR_CTRL, 32'h0);
		phaseStep(5'h00, 5'h04, 5'h10, 0);
		$display("test phase done");
	endtask

	initial begin
		tick(10);
		rst <= 1'b0;
		tick(2);
		testRegs;
		testStates;
		testModes;
		testRatios;
		testPhase;
		results;
	end
endmodule // differential_clock_mode_control_test
